/* rtl/eif_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef EIF_MAP_SVH
`define EIF_MAP_SVH
`define EIF_ADDR_CTRL 8'h37
`define EIF_ADDR_STAT 8'h40
`define EIF_ADDR_MASK 8'h41
`define EIF_ADDR_LVL 8'h42
`define EIF_CTRL_RST 8'h00
`define EIF_CTRL_WMASK 8'hFE
`define EIF_STAT_RST 6'h00
`define EIF_MASK_RST 6'h00
`define EIF_BIT_NOISE 7
`define EIF_BIT_PINSEL 6
`define EIF_FLD_TRIG3 5:4
`define EIF_FLD_TRIG4 3:2
`define EIF_BIT_TRIG1 1
`define EIF_STAT_TRAP 5
`define EIF_SYS_HZ 100000000
`define EIF_FC_HZ 100000000
`define EIF_SYS_PER_FC (`EIF_SYS_HZ / `EIF_FC_HZ)
`define EIF_ACC_FC_05 7
`define EIF_ACC_FC_1L 193
`define EIF_ACC_FC_1S 49
`define EIF_ACC_FC_34 25
`define EIF_ACC_FS_X2 7
`define EIF_CYC_05 8'(`EIF_ACC_FC_05 * `EIF_SYS_PER_FC)
`define EIF_CYC_1L 8'(`EIF_ACC_FC_1L * `EIF_SYS_PER_FC)
`define EIF_CYC_1S 8'(`EIF_ACC_FC_1S * `EIF_SYS_PER_FC)
`define EIF_CYC_34 8'(`EIF_ACC_FC_34 * `EIF_SYS_PER_FC)
`define EIF_TICK_SLOW 8'(`EIF_ACC_FS_X2 / 2)
`endif

/* rtl/eif_pkg.sv */
// types shared by the external interrupt filter modules
package eif_pkg;
  typedef enum logic [1:0] {
    EIF_TRIG_RISE = 2'h0,
    EIF_TRIG_FALL = 2'h1,
    EIF_TRIG_BOTH = 2'h2,
    EIF_TRIG_HIGH = 2'h3
  } eif_trig_type;
  typedef struct packed {
    logic [1:0] warm;
    logic primed;
    logic s1;
    logic s2;
    logic filt;
    logic rise;
    logic fall;
    logic [7:0] cnt;
  } eif_flt_state_type;
  typedef struct packed {
    logic reset_req;
    logic trap_irq;
  } eif_trap_state_type;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [5:0] stat;
    logic [5:0] mask;
    logic [7:0] rdata;
    logic [4:0] armed;
    logic [4:0] latch;
    logic [4:0] req;
    logic port;
  } eif_top_state_type;
endpackage

/* rtl/eif_flt_if.sv */
// per-channel link between the controller and one noise filter
`timescale 1ns/1ps
interface eif_flt_if;
  logic pin;
  logic tick;
  logic [7:0] thresh;
  logic level;
  logic rise;
  logic fall;
  modport filt (input pin, input tick, input thresh, output level, output rise, output fall);
  modport ctl (output pin, output tick, output thresh, input level, input rise, input fall);
endinterface

/* rtl/eif_noise_filter.sv */
// one synchroniser plus stability-counter noise filter
`timescale 1ns/1ps
module eif_noise_filter
  import eif_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  eif_flt_if.filt f
);
  eif_flt_state_type q;
  eif_flt_state_type next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = f.pin;
    next_q.s2 = q.s1;
    next_q.warm = {q.warm[0], 1'b1};
    next_q.rise = 1'b0;
    next_q.fall = 1'b0;
    if (!q.primed) begin
      // adopt the settled level without an edge, so a pin high at release is silent
      if (q.warm[1]) begin
        next_q.primed = 1'b1;
        next_q.filt = q.s2;
      end
    end else if (q.s2 == q.filt) begin
      next_q.cnt = 8'h00;
    end else if (f.tick) begin
      // threshold is compared live, so a new noise time acts at once
      if (q.cnt + 8'h01 >= f.thresh) begin
        next_q.filt = q.s2;
        next_q.cnt = 8'h00;
        next_q.rise = q.s2;
        next_q.fall = !q.s2;
      end else begin
        next_q.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign f.level = q.filt;
  assign f.rise = q.rise;
  assign f.fall = q.fall;

  filt_settle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(q.filt) && $past(q.primed) |->
      $past(q.cnt) + 8'h01 >= $past(f.thresh) && $past(f.tick))
    else $error("filter output changed before the stability count");
endmodule

/* rtl/eif_fetch_trap.sv */
// routes an illegal-area fetch to reset or to the trap interrupt
`timescale 1ns/1ps
module eif_fetch_trap
  import eif_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic fetch_in_trap,
  input wire logic trap_irq_mode,
  output logic trap_reset,
  output logic fetch_trap_irq
);
  eif_trap_state_type q;
  eif_trap_state_type next_q;

  always_comb begin
    // no gating by masks or by a running nmi: the trap must preempt anything
    next_q.reset_req = fetch_in_trap && !trap_irq_mode;
    next_q.trap_irq = fetch_in_trap && trap_irq_mode;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign trap_reset = q.reset_req;
  assign fetch_trap_irq = q.trap_irq;

  trap_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fetch_in_trap && clk_en |=> (trap_reset != fetch_trap_irq)
      && (trap_reset == !$past(trap_irq_mode)))
    else $error("trap fetch not routed to exactly one outcome");
  trap_take_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fetch_in_trap && trap_irq_mode && clk_en |=> fetch_trap_irq && !trap_reset)
    else $error("trap interrupt not raised on the next cycle");
endmodule

/* rtl/eif_ext_irq_filter.sv */
// external interrupt front end: filters, trigger select, latches, registers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "eif_map.svh"

// Function
// - illegal-area fetch gives reset or trap interrupt, chosen by watchdog control bit
// - trap interrupt taken at once, even while a non-maskable interrupt runs
// - five external interrupt inputs, each with a digital noise filter
// - inputs zero and five fall-edge only; zero needs master, flag and pin select
// - inputs zero and five reject under 2, accept 7 fast clocks or more
// - input one rejects under 63 or 15, accepts 193 or 49 fast clocks
// - inputs three and four reject under 7, accept 25 fast clocks or more
// - in slow modes all filters reject under 1, accept 3.5 slow clocks
// - clean edge sets latch within acceptance time plus six slow clocks
// - with pin select clear, latch zero never sets; pin is a plain port
// - control bit 6 picks port or interrupt zero; reset picks port
// - three and four: rise, fall, both, high; one: rise or fall
// - only inputs one, three and four have selectable triggers
// - new noise time of input one applies within 64 fast clocks
// - high-level mode needs a rising edge after reset before any request
// - shared pins driven as outputs may fake requests; software masks them
module eif_ext_irq_filter
  import eif_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_three,
  input wire logic ext_irq_four,
  input wire logic ext_irq_five,
  input wire logic low_speed_mode,
  input wire logic low_freq_tick,
  input wire logic master_irq_enable,
  input wire logic enable_flag_four,
  input wire logic enable_flag_five,
  input wire logic enable_flag_eleven,
  input wire logic enable_flag_fourteen,
  input wire logic enable_flag_fifteen,
  input wire logic latch_eleven_gate,
  input wire logic fetch_in_trap,
  input wire logic trap_irq_mode,
  output logic [4:0] irq_latch_set,
  output logic [4:0] irq_request,
  output logic shared_port_bit,
  output logic trap_reset,
  output logic fetch_trap_irq,
  output logic irq
);

  // ----------------------------------------
  // state and channel wiring
  // ----------------------------------------
  eif_top_state_type q;
  eif_top_state_type next_q;
  logic [4:0] pin_v;
  logic [4:0] lvl;
  logic [4:0] ch_rise;
  logic [4:0] ch_fall;
  logic [4:0] ev;
  logic [4:0] en;
  logic [7:0] thr [5];
  logic tick;
  logic pin_sel;
  logic [5:0] clr;
  eif_trig_type trig3;
  eif_trig_type trig4;

  // channel order: zero, one, three, four, five
  assign pin_v = {ext_irq_five, ext_irq_four, ext_irq_three, ext_irq_one, ext_irq_zero};
  assign pin_sel = q.ctrl[`EIF_BIT_PINSEL];
  assign trig3 = eif_trig_type'(q.ctrl[`EIF_FLD_TRIG3]);
  assign trig4 = eif_trig_type'(q.ctrl[`EIF_FLD_TRIG4]);

  // ----------------------------------------
  // noise filters
  // ----------------------------------------
  // slow modes count low clock ticks; 3 ticks of stability lie in 2..3.5 periods
  assign tick = low_speed_mode ? low_freq_tick : 1'b1;

  always_comb begin
    thr[0] = `EIF_CYC_05;
    thr[4] = `EIF_CYC_05;
    thr[1] = q.ctrl[`EIF_BIT_NOISE] ? `EIF_CYC_1S : `EIF_CYC_1L;
    thr[2] = `EIF_CYC_34;
    thr[3] = `EIF_CYC_34;
    if (low_speed_mode) begin
      for (int k = 0; k < 5; k++) begin
        thr[k] = `EIF_TICK_SLOW;
      end
    end
  end

  eif_flt_if flt[5] ();

  generate
    for (genvar k = 0; k < 5; k++) begin : g_ch
      assign flt[k].pin = pin_v[k];
      assign flt[k].tick = tick;
      assign flt[k].thresh = thr[k];
      assign lvl[k] = flt[k].level;
      assign ch_rise[k] = flt[k].rise;
      assign ch_fall[k] = flt[k].fall;
      // one filter per input keeps glitches off every line
      eif_noise_filter u_flt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .f(flt[k])
      );
    end
  endgenerate

  // ----------------------------------------
  // fetch trap
  // ----------------------------------------
  eif_fetch_trap u_trap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .fetch_in_trap(fetch_in_trap),
    .trap_irq_mode(trap_irq_mode),
    .trap_reset(trap_reset),
    .fetch_trap_irq(fetch_trap_irq)
  );

  // ----------------------------------------
  // trigger detection and enables
  // ----------------------------------------
  always_comb begin
    // fixed trigger on zero and five, selectable on the rest
    ev[0] = ch_fall[0] && pin_sel;
    ev[4] = ch_fall[4];
    ev[1] = q.ctrl[`EIF_BIT_TRIG1] ? ch_fall[1] : ch_rise[1];
    unique case (trig3)
      EIF_TRIG_RISE: ev[2] = ch_rise[2];
      EIF_TRIG_FALL: ev[2] = ch_fall[2];
      EIF_TRIG_BOTH: ev[2] = ch_rise[2] || ch_fall[2];
      EIF_TRIG_HIGH: ev[2] = lvl[2] && (q.armed[2] || ch_rise[2]);
    endcase
    unique case (trig4)
      EIF_TRIG_RISE: ev[3] = ch_rise[3];
      EIF_TRIG_FALL: ev[3] = ch_fall[3];
      EIF_TRIG_BOTH: ev[3] = ch_rise[3] || ch_fall[3];
      EIF_TRIG_HIGH: ev[3] = lvl[3] && (q.armed[3] || ch_rise[3]);
    endcase
  end

  always_comb begin
    // enable flags mask requests; software drops them around pin reconfiguration
    en[0] = master_irq_enable && enable_flag_four && pin_sel;
    en[1] = master_irq_enable && enable_flag_five;
    en[2] = master_irq_enable && enable_flag_eleven && latch_eleven_gate;
    en[3] = master_irq_enable && enable_flag_fourteen;
    en[4] = master_irq_enable && enable_flag_fifteen;
  end

  // ----------------------------------------
  // registers and next state
  // ----------------------------------------
  assign clr = (reg_wr && reg_addr == `EIF_ADDR_STAT) ? reg_wdata[5:0] : 6'h00;

  always_comb begin
    next_q = q;
    next_q.armed = q.armed | ch_rise;
    next_q.latch = ev;
    next_q.req = ev & en;
    // port read path only while the pin is not claimed by the interrupt
    next_q.port = pin_sel ? 1'b0 : ext_irq_zero;
    // a new event beats a clear in the same cycle
    next_q.stat = (q.stat & ~clr) | {fetch_trap_irq, ev};
    if (reg_wr) begin
      if (reg_addr == `EIF_ADDR_CTRL) begin
        // a rewrite may upset filters mid-count; software masks first
        next_q.ctrl = reg_wdata & `EIF_CTRL_WMASK;
      end
      if (reg_addr == `EIF_ADDR_MASK) begin
        next_q.mask = reg_wdata[5:0];
      end
    end
    next_q.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `EIF_ADDR_CTRL: next_q.rdata = q.ctrl;
        `EIF_ADDR_STAT: next_q.rdata = {2'h0, q.stat};
        `EIF_ADDR_MASK: next_q.rdata = {2'h0, q.mask};
        `EIF_ADDR_LVL: next_q.rdata = {3'h0, lvl};
        default: next_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q.ctrl <= `EIF_CTRL_RST;
      q.stat <= `EIF_STAT_RST;
      q.mask <= `EIF_MASK_RST;
      q.rdata <= 8'h00;
      q.armed <= 5'h00;
      q.latch <= 5'h00;
      q.req <= 5'h00;
      q.port <= 1'b0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq_latch_set = q.latch;
  assign irq_request = q.req;
  assign shared_port_bit = q.port;
  assign irq = |(q.stat & q.mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [7:0] fast_run;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fast_run <= 8'h00;
    end else if (clk_en && !low_speed_mode) begin
      fast_run <= (fast_run == 8'hFF) ? fast_run : fast_run + 8'h01;
    end else begin
      fast_run <= 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence fast_settled(int n);
    fast_run >= n;
  endsequence

  zero_fall_a: assert property (irq_latch_set[0] |-> !lvl[0])
    else $error("input zero latched without a falling level");

  five_fall_a: assert property (irq_latch_set[4] |-> !lvl[4])
    else $error("input five latched without a falling level");

  port_select_a: assert property (irq_latch_set[0] |-> $past(pin_sel))
    else $error("input zero latched while pin is a port");

  zero_reject_a: assert property (
    fast_settled(12) and $fell(lvl[0]) |-> !$past(ext_irq_zero, 3) && !$past(ext_irq_zero, 4))
    else $error("input zero accepted a pulse under two clocks");

  one_reject_a: assert property (
    fast_settled(24) and $changed(lvl[1]) |->
      $past(ext_irq_one, 3) == lvl[1] && $past(ext_irq_one, 17) == lvl[1])
    else $error("input one accepted a pulse under fifteen clocks");

  three_reject_a: assert property (
    fast_settled(12) and $rose(lvl[2]) |-> $past(ext_irq_three, 3) && $past(ext_irq_three, 9))
    else $error("input three accepted a pulse under seven clocks");

  both_edge_a: assert property (
    $past(clk_en) && $past(trig4) == EIF_TRIG_BOTH && $past(ch_rise[3] || ch_fall[3])
      |-> irq_latch_set[3])
    else $error("both-edge mode missed an edge on input four");

  level_arm_a: assert property (
    irq_latch_set[2] && $past(trig3) == EIF_TRIG_HIGH |-> q.armed[2])
    else $error("level request on input three without a prior rise");

  status_hold_a: assert property (
    ev[1] && clk_en |=> q.stat[1] && irq == q.mask[1] || |(q.stat & q.mask))
    else $error("event did not set its status bit");

  // ----------------------------------------
  // request, port and register checks
  // ----------------------------------------
  zero_gate_a: assert property (
    irq_request[0] |-> $past(master_irq_enable && enable_flag_four && pin_sel))
    else $error("input zero requested without its enables");

  one_gate_a: assert property (
    irq_request[1] |-> $past(master_irq_enable && enable_flag_five))
    else $error("input one requested without its enables");

  three_gate_a: assert property (
    irq_request[2] |-> $past(master_irq_enable && enable_flag_eleven && latch_eleven_gate))
    else $error("input three requested without its enables");

  four_gate_a: assert property (
    irq_request[3] |-> $past(master_irq_enable && enable_flag_fourteen))
    else $error("input four requested without its enables");

  five_gate_a: assert property (
    irq_request[4] |-> $past(master_irq_enable && enable_flag_fifteen))
    else $error("input five requested without its enables");

  req_latch_a: assert property ((irq_request & ~irq_latch_set) == 5'h00)
    else $error("request without its latch pulse");

  req_given_a: assert property (
    $past(clk_en) && irq_latch_set[2]
      && $past(master_irq_enable && enable_flag_eleven && latch_eleven_gate)
      |-> irq_request[2])
    else $error("enabled latch on input three gave no request");

  five_latch_a: assert property ($past(clk_en && ch_fall[4]) |-> irq_latch_set[4])
    else $error("filtered fall on input five not latched next cycle");

  rise_only_a: assert property (
    $past(clk_en) && $past(trig3) == EIF_TRIG_RISE |-> irq_latch_set[2] == $past(ch_rise[2]))
    else $error("rise mode on input three mismatched");

  fall_only_a: assert property (
    $past(clk_en) && $past(trig4) == EIF_TRIG_FALL |-> irq_latch_set[3] == $past(ch_fall[3]))
    else $error("fall mode on input four mismatched");

  one_edge_a: assert property (
    $past(clk_en) |->
      irq_latch_set[1] == $past(q.ctrl[`EIF_BIT_TRIG1] ? ch_fall[1] : ch_rise[1]))
    else $error("input one edge select mismatched");

  level_hold_a: assert property (
    $past(clk_en) && $past(trig3) == EIF_TRIG_HIGH && $past(lvl[2] && q.armed[2])
      |-> irq_latch_set[2])
    else $error("armed high level on input three gave no latch");

  port_mirror_a: assert property (
    $past(clk_en) && $past(nrst) && !$past(pin_sel) |-> shared_port_bit == $past(ext_irq_zero))
    else $error("port bit does not follow the shared pin");

  port_claim_a: assert property ($past(clk_en && pin_sel) |-> !shared_port_bit)
    else $error("port bit shows the pin while claimed");

  set_wins_a: assert property ($past(clk_en && ev[4]) |-> q.stat[4])
    else $error("status clear beat a new event");

  trap_status_a: assert property (
    $past(clk_en && fetch_trap_irq) |-> q.stat[`EIF_STAT_TRAP])
    else $error("trap interrupt did not set its status bit");

  rdata_idle_a: assert property ($past(clk_en && !reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read answer");

  rdata_ctrl_a: assert property (
    $past(clk_en && reg_rd && reg_addr == `EIF_ADDR_CTRL) |-> reg_rdata == $past(q.ctrl))
    else $error("control read returned a wrong value");
endmodule

/* testbench/eif_pin_src.sv */
// pin source model: idles each external interrupt pin and drives clean pulses
`timescale 1ns/1ps
module eif_pin_src #(
  parameter logic [4:0] idle_lvl = 5'h11
) (
  input wire logic sys_clk,
  output logic [4:0] pin
);
  initial pin = idle_lvl;
  // leave idle just after an edge, so the pin differs for exactly len samples
  task automatic pulse(input int ch, input int len);
    @(posedge sys_clk);
    pin[ch] <= ~idle_lvl[ch];
    repeat (len) @(posedge sys_clk);
    pin[ch] <= idle_lvl[ch];
  endtask
  task automatic hold(input int ch, input logic v);
    pin[ch] <= v;
  endtask
endmodule

/* testbench/eif_ext_irq_filter_tb.sv */
// self-checking bench for the external interrupt front end
`timescale 1ns/1ps
`include "eif_map.svh"
module eif_ext_irq_filter_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic low_speed_mode = 1'b0;
  logic low_freq_tick = 1'b0;
  logic fetch_in_trap = 1'b0;
  logic trap_irq_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] en = 7'h7F;
  logic [7:0] reg_rdata;
  logic [4:0] pins, irq_latch_set, irq_request;
  logic shared_port_bit, trap_reset, fetch_trap_irq, irq;
  logic [11:0] q_ev[$];
  logic [7:0] q_rd[$];
  logic rd_seen = 1'b0;
  logic [31:0] lfsr = 32'hF7FD44F6;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int tdiv = 0;
  // -------------------------------------------------
  // stimulus table: control value, channel, pulse length, events
  // -------------------------------------------------
  logic [7:0] t_c[17] = '{8'hC4, 8'hC4, 8'hC4, 8'hC4, 8'hC4, 8'hC4, 8'h44, 8'h44, 8'hC4,
                          8'hC4, 8'hC4, 8'hC4, 8'h84, 8'hC6, 8'hD4, 8'hE4, 8'hC8};
  int t_ch[17] = '{0, 0, 4, 4, 1, 1, 1, 1, 2, 2, 3, 3, 0, 1, 2, 2, 3};
  int t_len[17] = '{7, 1, 7, 1, 49, 14, 193, 62, 25, 6, 25, 6, 7, 49, 25, 25, 25};
  int t_hit[17] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1, 1, 2, 2};

  always #5 sys_clk = ~sys_clk;

  eif_pin_src #(.idle_lvl(5'h11)) src (.sys_clk(sys_clk), .pin(pins));

  eif_ext_irq_filter DUT (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ext_irq_zero(pins[0]), .ext_irq_one(pins[1]), .ext_irq_three(pins[2]),
    .ext_irq_four(pins[3]), .ext_irq_five(pins[4]),
    .low_speed_mode(low_speed_mode), .low_freq_tick(low_freq_tick),
    .master_irq_enable(en[6]), .enable_flag_four(en[5]), .enable_flag_five(en[4]),
    .enable_flag_eleven(en[3]), .enable_flag_fourteen(en[2]), .enable_flag_fifteen(en[1]),
    .latch_eleven_gate(en[0]), .fetch_in_trap(fetch_in_trap), .trap_irq_mode(trap_irq_mode),
    .irq_latch_set(irq_latch_set), .irq_request(irq_request),
    .shared_port_bit(shared_port_bit), .trap_reset(trap_reset),
    .fetch_trap_irq(fetch_trap_irq), .irq(irq)
  );

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // request gating per channel, zero also needs the pin select
  function automatic logic [4:0] gate_of(input logic [6:0] e, input logic [7:0] c);
    return {e[6] & e[1], e[6] & e[2], e[6] & e[3] & e[0], e[6] & e[4], e[6] & e[5] & c[6]};
  endfunction

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    q_rd.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // settle the control value, pulse one pin, then expect hit events
  task automatic run(input logic [7:0] c, input int ch, input int len, input int hit);
    logic [4:0] b;
    b = 5'h01 << ch;
    lfsr = next_rand(lfsr);
    en <= lfsr[6:0];
    wr(`EIF_ADDR_CTRL, c);
    repeat (64) @(posedge sys_clk);
    for (int i = 0; i < hit; i++) q_ev.push_back({2'b00, b, b & gate_of(lfsr[6:0], c)});
    src.pulse(ch, len);
    repeat (300) @(posedge sys_clk);
    check("events left", 12'h000, 12'(q_ev.size()));
    q_ev.delete();
  endtask

  // -------------------------------------------------
  // output watcher, slow tick and timeout
  // -------------------------------------------------
  always @(posedge sys_clk) begin
    logic [11:0] ev;
    ev = {fetch_trap_irq, trap_reset, irq_latch_set, irq_request};
    // outputs are unknown until the first reset edge
    if (nrst && ev !== 12'h000) begin
      if (q_ev.size() == 0) check("unexpected event", 12'h000, ev);
      else check("event", q_ev.pop_front(), ev);
    end
    if (rd_seen) check("read data", {4'h0, q_rd.pop_front()}, {4'h0, reg_rdata});
    rd_seen <= reg_rd;
    tdiv <= (tdiv == 3) ? 0 : tdiv + 1;
    low_freq_tick <= (tdiv == 3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`EIF_ADDR_CTRL, `EIF_CTRL_RST);
    rd(`EIF_ADDR_STAT, 8'h00);
    rd(`EIF_ADDR_MASK, 8'h00);
    rd(8'h10, 8'h00);
    repeat (5) @(posedge sys_clk);
    rd(`EIF_ADDR_LVL, 8'h11);
    check("port bit", 12'h001, {11'h000, shared_port_bit});
    wr(`EIF_ADDR_CTRL, 8'hFF);
    rd(`EIF_ADDR_CTRL, 8'hFE);
    repeat (3) @(posedge sys_clk);
    check("port bit", 12'h000, {11'h000, shared_port_bit});
    for (int k = 0; k < 17; k++) begin
      run(t_c[k], t_ch[k], t_len[k], t_hit[k]);
    end
    // pins stay quiet while the clock mode changes
    low_speed_mode <= 1'b1;
    run(8'hC4, 4, 16, 1);
    run(8'hC4, 4, 3, 0);
    low_speed_mode <= 1'b0;
    wr(`EIF_ADDR_MASK, 8'h3F);
    wr(`EIF_ADDR_STAT, 8'h3F);
    en <= 7'h00;
    @(posedge sys_clk);
    fetch_in_trap <= 1'b1;
    q_ev.push_back(12'h400);
    @(posedge sys_clk);
    trap_irq_mode <= 1'b1;
    q_ev.push_back(12'h800);
    @(posedge sys_clk);
    fetch_in_trap <= 1'b0;
    run(8'hC4, 4, 7, 1);
    rd(`EIF_ADDR_STAT, 8'h30);
    check("irq", 12'h001, {11'h000, irq});
    wr(`EIF_ADDR_MASK, 8'h00);
    #1 check("irq masked", 12'h000, {11'h000, irq});
    wr(`EIF_ADDR_MASK, 8'h3F);
    wr(`EIF_ADDR_STAT, 8'h30);
    rd(`EIF_ADDR_STAT, 8'h00);
    #1 check("irq cleared", 12'h000, {11'h000, irq});
    // second reset with pin three already high
    @(posedge sys_clk);
    nrst <= 1'b0;
    src.hold(2, 1'b1);
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`EIF_ADDR_CTRL, 8'h00);
    wr(`EIF_ADDR_CTRL, 8'h70);
    repeat (200) @(posedge sys_clk);
    check("level events", 12'h000, 12'(q_ev.size()));
    // after a real rise the high level requests once per cycle while it stands
    src.hold(2, 1'b0);
    repeat (40) @(posedge sys_clk);
    for (int i = 0; i < 30; i++) q_ev.push_back({2'b00, 5'h04, 5'h04 & gate_of(en, 8'h70)});
    src.pulse(2, 30);
    repeat (60) @(posedge sys_clk);
    check("level events left", 12'h000, 12'(q_ev.size()));
    rd(`EIF_ADDR_STAT, 8'h04);
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule
